// >>> hw/rbt_clk_div.sv
// Divider: one-cycle enable pulse every div_cycles clocks
// Assumes: div_cycles at least 1, changes are compared against the running count at once
`timescale 1ns/1ns
`default_nettype none
module rbt_clk_div
   import rbt_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         restart,
   input  wire logic [W-1:0] div_cycles,
   output logic              tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } rbt_div_s;

   rbt_div_s st;
   rbt_div_s next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (restart) begin
         next_st.cnt = '0;
      end else if (st.cnt + W'(1) >= div_cycles) begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + W'(1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule
`default_nettype wire

// >>> hw/rbt_cs_debounce.sv
// Carrier sense debouncer: set after N hits, release after 1 or 2 misses
// Assumes: sample_en marks each carrier level comparison
`timescale 1ns/1ns
`default_nettype none
module rbt_cs_debounce
   import rbt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       sample_en,
   input  wire logic       above,
   input  wire logic [1:0] set_count,
   input  wire logic       release_two,
   output logic            carrier
);
   typedef struct packed {
      logic [2:0] hits;
      logic [1:0] misses;
      logic       carrier;
   } rbt_deb_s;

   rbt_deb_s st;
   rbt_deb_s next_st;

   always_comb begin
      next_st = st;
      if (sample_en) begin
         if (above) begin
            next_st.misses = '0;
            if (st.hits < 3'h4) begin
               next_st.hits = st.hits + 3'h1;
            end
            if ({1'b0, set_count} + 3'h1 <= st.hits + 3'h1) begin
               next_st.carrier = 1'b1; // RULE10
            end
         end else begin
            next_st.hits = '0;
            if (st.misses < 2'h2) begin
               next_st.misses = st.misses + 2'h1;
            end
            if (!release_two || st.misses >= 2'h1) begin
               next_st.carrier = 1'b0; // RULE11
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign carrier = st.carrier;

   property p_set_needs_hits;
      @(posedge clk) disable iff (reset)
      $rose(st.carrier) |-> $past(st.hits) >= {1'b0, set_count};
   endproperty
   a_set_needs_hits: assert property (p_set_needs_hits) // RULE10
      else $error("carrier set too early");

   property p_release_two;
      @(posedge clk) disable iff (reset)
      $fell(st.carrier) && release_two |-> $past(st.misses) >= 2'h1;
   endproperty
   a_release_two: assert property (p_release_two) // RULE11
      else $error("carrier released after one miss");
endmodule
`default_nettype wire

// >>> hw/rbt_pkg.sv
// Package: shared constants and types for the receive baseband tuning block
// Assumes: 125 MHz single clock, classic Wishbone register access
package rbt_pkg;
   // -----------------------------
   // Register map (word indices and byte addresses)
   // -----------------------------
   localparam logic [7:0] FREQ_CORRECTION_CTRL_IDX   = 8'h0f;
   localparam logic [7:0] CHANNEL_FILTER_CTRL_IDX    = 8'h10;
   localparam logic [7:0] GAIN_HOLD_CARRIER_CTRL_IDX = 8'h11;
   localparam logic [7:0] IRQ_STATUS_IDX             = 8'h12;
   localparam logic [7:0] IRQ_MASK_IDX               = 8'h13;
   localparam logic [7:0] BLOCK_STATUS_IDX           = 8'h14;
   localparam logic [9:0] FREQ_CORRECTION_CTRL_ADDR  = 10'h03c;
   localparam logic [9:0] CHANNEL_FILTER_CTRL_ADDR   = 10'h040;
   localparam logic [9:0] GAIN_HOLD_CARRIER_CTRL_ADDR = 10'h044;
   localparam logic [9:0] IRQ_STATUS_ADDR            = 10'h048;
   localparam logic [9:0] IRQ_MASK_ADDR              = 10'h04c;
   localparam logic [9:0] BLOCK_STATUS_ADDR          = 10'h050;
   // -----------------------------
   // Reset values
   // -----------------------------
   localparam logic [7:0] FREQ_CORRECTION_CTRL_RST   = 8'h9c;
   localparam logic [7:0] CHANNEL_FILTER_CTRL_RST    = 8'h00;
   localparam logic [7:0] GAIN_HOLD_CARRIER_CTRL_RST = 8'h65;
   localparam logic [2:0] CONVERTER_DIV_SEL_RST      = 3'h3;
   // -----------------------------
   // Field positions
   // -----------------------------
   localparam int SETTLE_LSB    = 6;
   localparam int RX_DEVIATION_EXPONENT_LSB   = 4;
   localparam int BYPASS_BIT    = 7;
   localparam int DSHIFT_LSB    = 5;
   localparam int CS_SET_LSB    = 6;
   localparam int CS_REL_BIT    = 5;
   localparam int GHOLD_LSB     = 2;
   // Interrupt bits
   localparam int IRQ_CS_RISE   = 0;
   localparam int IRQ_CS_FALL   = 1;
   localparam int IRQ_FREEZE_END = 2;
   // -----------------------------
   // Hold tables (filter clocks, converter clocks)
   // -----------------------------
   localparam logic [7:0] GAIN_HOLD_BASE = 8'h10;
   localparam logic [7:0] EXTRA_HOLD_BASE = 8'h10;
   localparam logic [2:0] GAIN_HOLD_FOREVER = 3'h7;
   // Filter clock at 2x 307.2 kHz from 125 MHz: rounded down to 203 cycles
   localparam int CLK_HZ            = 125000000;
   localparam int FILTER_BASE_HZ    = 614400;
   localparam int FILTER_BASE_CYC   = CLK_HZ / FILTER_BASE_HZ;

   typedef enum logic [1:0] {RBT_HOLD_IDLE, RBT_HOLD_GAIN, RBT_HOLD_EXTRA}
      rbt_hold_e;

   typedef struct packed {
      logic [1:0] settle;
      logic [1:0] dev_exp;
      logic [3:0] dev_mant;
   } rbt_fc_s;

   typedef struct packed {
      logic       bypass;
      logic [1:0] dshift;
      logic [4:0] ddiv;
   } rbt_filt_s;

   typedef struct packed {
      logic [1:0] cs_set;
      logic       cs_rel;
      logic [2:0] ghold;
      logic [1:0] xhold;
   } rbt_hold_s;
endpackage

// >>> hw/rbt_tuning_regs.sv
// Receive baseband tuning: registers, frequency averaging, filter config,
// carrier sense debounce and gain-change hold timers.
// Assumes: classic Wishbone master, all inputs synchronous to CLK.
//
// Contract
// RULE1: Settle select 0 disables correction; zero average offset to demodulator.
// RULE2: Settle 1,2,3 averages frequency over 1,2,4 zero/one bit pairs.
// RULE3: Host should choose settle select 3 unless fastest settling needed.
// RULE4: Expected deviation is baud times mantissa times 2^(exp-3) over 3.
// RULE5: Host keeps deviation mantissa between 8 and 15 by adjusting exponent.
// RULE6: Host sets deviation near half or full transmit deviation by rate.
// RULE7: Filter skip bit bypasses anti-alias filter; host sets it at 76.8k up.
// RULE8: Decimator input shift adds that many shift bits; host picks per divisor.
// RULE9: Decimation divisor is field plus one; bandwidth is 307.2 kHz over it.
// RULE10: Carrier sense asserts after set count plus one samples at level.
// RULE11: Carrier sense releases after one, or two when release bit set.
// RULE12: Host should set release count bit to one.
// RULE13: Gain change events freeze gain, bit-sync, correction and strength.
// RULE14: Gain hold codes 0-6 give 16..48 filter clocks; 7 holds forever.
// RULE15: Extra hold adds 16, 32, 64 or 128 converter clocks.
// RULE16: Converter clock is oscillator divided by even 4..16 from 3-bit code; here code 0 divides by 2.
// RULE17: New event during freeze restarts both hold counters.
// RULE18: Filter clock runs at twice channel filter bandwidth.
`timescale 1ns/1ns
`default_nettype none
module rbt_tuning_regs
   import rbt_pkg::*;
#(
   parameter int FW = 16
) (
   input  wire logic          CLK,
   input  wire logic          RESET,
   // Wishbone slave
   input  wire logic          WB_CYC_I,
   input  wire logic          WB_STB_I,
   input  wire logic          WB_WE_I,
   input  wire logic [9:0]    WB_ADR_I,
   input  wire logic [3:0]    WB_SEL_I,
   input  wire logic [31:0]   WB_DAT_I,
   output logic [31:0]        WB_DAT_O,
   output logic               WB_ACK_O,
   // Baseband side
   input  wire logic [2:0]    CONVERTER_DIV_SEL,
   input  wire logic [FW-1:0] FREQ_EST,
   input  wire logic          BIT_PAIR_DONE,
   input  wire logic          CS_SAMPLE,
   input  wire logic          CS_ABOVE,
   input  wire logic          FREQ_SWITCH,
   input  wire logic          SYNTH_UNLOCK,
   input  wire logic          RX_POWER_UP,
   output logic [FW-1:0]      AVG_FREQ_OFFSET,
   output logic               FREQ_CORR_EN,
   output logic [3:0]         RX_DEVIATION_MANTISSA,
   output logic [1:0]         RX_DEVIATION_EXPONENT,
   output logic               FILTER_BYPASS_EN,
   output logic [1:0]         DECIMATOR_INPUT_SHIFT,
   output logic [5:0]         DECIMATION_DIVISOR,
   output logic               CARRIER_SENSE,
   output logic               LEVELS_FROZEN,
   output logic               IRQ
);
   // -----------------------------
   // State
   // -----------------------------
   typedef struct packed {
      rbt_fc_s         fc;
      rbt_filt_s       filt;
      rbt_hold_s       hold;
      logic [2:0]      irq_stat;
      logic [2:0]      irq_mask;
      logic            ack;
      logic [31:0]     rdata;
      logic [FW+1:0]   acc;
      logic [2:0]      pairs;
      logic [FW-1:0]   avg;
      rbt_hold_e       hstate;
      logic [7:0]      hcnt;
      logic            carrier_q;
   } rbt_st_s;

   rbt_st_s st;
   rbt_st_s next_st;

   logic       filt_tick;
   logic       conv_tick;
   logic       carrier;
   logic       event_in;
   logic       wr;
   logic       rd;
   logic [2:0] pair_goal;
   logic [7:0] ghold_len;
   logic [7:0] xhold_len;
   logic [FW-1:0] filt_div;
   logic [FW-1:0] conv_div;
   logic [FW+1:0] fe_ext;

   assign event_in = FREQ_SWITCH | SYNTH_UNLOCK | RX_POWER_UP; // RULE13
   assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~st.ack & WB_SEL_I[0];
   assign rd = WB_CYC_I & WB_STB_I & ~st.ack;
   assign fe_ext = {{2{FREQ_EST[FW-1]}}, FREQ_EST};

   // -----------------------------
   // Rate dividers
   // -----------------------------
   // Filter clock period = base cycles times divisor (twice the bandwidth)
   assign filt_div = FW'(FILTER_BASE_CYC) * FW'({1'b0, st.filt.ddiv} + 6'h1); // RULE18
   // Converter clock: the 125 MHz clock stands in for the oscillator
   assign conv_div = FW'({CONVERTER_DIV_SEL, 1'b0}) + FW'(2); // RULE16

   rbt_clk_div #(.W(FW)) u_filt_div (
      .clk        (CLK),
      .reset      (RESET),
      .restart    (event_in),
      .div_cycles (filt_div),
      .tick       (filt_tick)
   );

   rbt_clk_div #(.W(FW)) u_conv_div (
      .clk        (CLK),
      .reset      (RESET),
      .restart    (event_in),
      .div_cycles (conv_div),
      .tick       (conv_tick)
   );

   rbt_cs_debounce u_cs (
      .clk         (CLK),
      .reset       (RESET),
      .sample_en   (CS_SAMPLE),
      .above       (CS_ABOVE),
      .set_count   (st.hold.cs_set),
      .release_two (st.hold.cs_rel),
      .carrier     (carrier)
   );

   // -----------------------------
   // Hold lengths
   // -----------------------------
   always_comb begin
      case (st.hold.ghold) // RULE14
         3'h0: ghold_len = 8'h10;
         3'h1: ghold_len = 8'h14;
         3'h2: ghold_len = 8'h18;
         3'h3: ghold_len = 8'h1c;
         3'h4: ghold_len = 8'h20;
         3'h5: ghold_len = 8'h28;
         3'h6: ghold_len = 8'h30;
         default: ghold_len = 8'hff;
      endcase
      xhold_len = EXTRA_HOLD_BASE << st.hold.xhold; // RULE15
      case (st.fc.settle) // RULE2
         2'h1: pair_goal = 3'h1;
         2'h2: pair_goal = 3'h2;
         default: pair_goal = 3'h4;
      endcase
   end

   // -----------------------------
   // Next state
   // -----------------------------
   always_comb begin
      next_st = st;
      next_st.ack = rd;
      next_st.carrier_q = carrier;
      // Register writes
      if (wr) begin
         case (WB_ADR_I)
            FREQ_CORRECTION_CTRL_ADDR: next_st.fc = WB_DAT_I[7:0];
            CHANNEL_FILTER_CTRL_ADDR: next_st.filt = WB_DAT_I[7:0];
            GAIN_HOLD_CARRIER_CTRL_ADDR: next_st.hold = WB_DAT_I[7:0];
            IRQ_MASK_ADDR: next_st.irq_mask = WB_DAT_I[2:0];
            IRQ_STATUS_ADDR:
               next_st.irq_stat = st.irq_stat & ~WB_DAT_I[2:0];
            default: ;
         endcase
      end
      // Register reads
      next_st.rdata = '0;
      case (WB_ADR_I)
         FREQ_CORRECTION_CTRL_ADDR: next_st.rdata[7:0] = st.fc;
         CHANNEL_FILTER_CTRL_ADDR: next_st.rdata[7:0] = st.filt;
         GAIN_HOLD_CARRIER_CTRL_ADDR: next_st.rdata[7:0] = st.hold;
         IRQ_STATUS_ADDR: next_st.rdata[2:0] = st.irq_stat;
         IRQ_MASK_ADDR: next_st.rdata[2:0] = st.irq_mask;
         BLOCK_STATUS_ADDR:
            next_st.rdata[1:0] = {st.hstate != RBT_HOLD_IDLE, carrier};
         default: ;
      endcase
      // Frequency averaging over bit pairs, frozen while holding
      if (st.fc.settle == 2'h0) begin
         next_st.avg = '0; // RULE1
         next_st.acc = '0;
         next_st.pairs = '0;
      end else if (BIT_PAIR_DONE && st.hstate == RBT_HOLD_IDLE) begin
         if (st.pairs + 3'h1 >= pair_goal) begin
            case (pair_goal) // RULE2
               3'h1: next_st.avg = FREQ_EST;
               3'h2: next_st.avg = FW'((st.acc + fe_ext) >>> 1);
               default: next_st.avg = FW'((st.acc + fe_ext) >>> 2);
            endcase
            next_st.acc = '0;
            next_st.pairs = '0;
         end else begin
            next_st.acc = st.acc + fe_ext;
            next_st.pairs = st.pairs + 3'h1;
         end
      end
      // Hold timers
      if (event_in) begin
         next_st.hstate = RBT_HOLD_GAIN; // RULE17
         next_st.hcnt = '0;
      end else begin
         case (st.hstate)
            RBT_HOLD_GAIN: begin
               if (st.hold.ghold == GAIN_HOLD_FOREVER) begin
                  next_st.hcnt = '0; // RULE14
               end else if (filt_tick) begin
                  if (st.hcnt + 8'h1 >= ghold_len) begin
                     next_st.hstate = RBT_HOLD_EXTRA;
                     next_st.hcnt = '0;
                  end else begin
                     next_st.hcnt = st.hcnt + 8'h1;
                  end
               end
            end
            RBT_HOLD_EXTRA: begin
               if (conv_tick) begin
                  if (st.hcnt + 8'h1 >= xhold_len) begin // RULE15
                     next_st.hstate = RBT_HOLD_IDLE;
                     next_st.hcnt = '0;
                     next_st.irq_stat[IRQ_FREEZE_END] = 1'b1;
                  end else begin
                     next_st.hcnt = st.hcnt + 8'h1;
                  end
               end
            end
            default: next_st.hstate = RBT_HOLD_IDLE;
         endcase
      end
      // Events set status; set wins over a clear in the same cycle
      if (carrier && !st.carrier_q) next_st.irq_stat[IRQ_CS_RISE] = 1'b1;
      if (!carrier && st.carrier_q) next_st.irq_stat[IRQ_CS_FALL] = 1'b1;
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st <= '0;
         st.fc <= FREQ_CORRECTION_CTRL_RST;
         st.filt <= CHANNEL_FILTER_CTRL_RST;
         st.hold <= GAIN_HOLD_CARRIER_CTRL_RST;
         st.hstate <= RBT_HOLD_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------
   // Outputs
   // -----------------------------
   assign WB_ACK_O = st.ack;
   assign WB_DAT_O = st.rdata;
   assign AVG_FREQ_OFFSET = st.avg;
   assign FREQ_CORR_EN = st.fc.settle != 2'h0; // RULE1
   assign RX_DEVIATION_MANTISSA = st.fc.dev_mant; // RULE4
   assign RX_DEVIATION_EXPONENT = st.fc.dev_exp;
   assign FILTER_BYPASS_EN = st.filt.bypass; // RULE7
   assign DECIMATOR_INPUT_SHIFT = st.filt.dshift; // RULE8
   assign DECIMATION_DIVISOR = {1'b0, st.filt.ddiv} + 6'h1; // RULE9
   assign CARRIER_SENSE = carrier;
   assign LEVELS_FROZEN = st.hstate != RBT_HOLD_IDLE; // RULE13
   assign IRQ = |(st.irq_stat & st.irq_mask);

   // -----------------------------
   // Checks
   // -----------------------------
   property p_zero_avg;
      @(posedge CLK) disable iff (RESET)
      st.fc.settle == 2'h0 |=> AVG_FREQ_OFFSET == '0;
   endproperty
   a_zero_avg: assert property (p_zero_avg) // RULE1
      else $error("offset not zero with correction off");

   property p_freeze_on_event;
      @(posedge CLK) disable iff (RESET)
      event_in |=> LEVELS_FROZEN && st.hcnt == 8'h0;
   endproperty
   a_freeze_on_event: assert property (p_freeze_on_event) // RULE17
      else $error("event did not start freeze");

   property p_forever;
      @(posedge CLK) disable iff (RESET)
      st.hstate == RBT_HOLD_GAIN && st.hold.ghold == GAIN_HOLD_FOREVER
         |=> st.hstate == RBT_HOLD_GAIN;
   endproperty
   a_forever: assert property (p_forever) // RULE14
      else $error("code 7 hold ended");

   property p_divisor;
      @(posedge CLK) disable iff (RESET)
      DECIMATION_DIVISOR >= 6'h1 && DECIMATION_DIVISOR <= 6'h20;
   endproperty
   a_divisor: assert property (p_divisor) // RULE9
      else $error("divisor out of range");

   property p_ack_one;
      @(posedge CLK) disable iff (RESET)
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

// >>> tb/rbt_bb_model.sv
// Baseband model: carrier samples, bit-pair estimates and gain events
// Assumes: driven by bench task calls, one clock domain
`timescale 1ns/1ns
`default_nettype none
module rbt_bb_model
   import rbt_pkg::*;
(
   input  wire logic        clk,
   output logic             cs_sample,
   output logic             cs_above,
   output logic [15:0]      freq_est,
   output logic             pair_done,
   output logic [2:0]       event_pulse
);
   initial begin
      cs_sample   = 1'b0;
      cs_above    = 1'b0;
      freq_est    = 16'h0000;
      pair_done   = 1'b0;
      event_pulse = 3'h0;
   end
   // Data flips after its strobe, so a stale value never looks held
   task automatic sample(input logic lvl);
      @(posedge clk);
      cs_sample <= 1'b1;
      cs_above  <= lvl;
      @(posedge clk);
      cs_sample <= 1'b0;
      cs_above  <= ~lvl;
   endtask
   task automatic pair(input logic [15:0] v);
      @(posedge clk);
      pair_done <= 1'b1;
      freq_est  <= v;
      @(posedge clk);
      pair_done <= 1'b0;
      freq_est  <= ~v;
   endtask
   task automatic gain_event(input int k);
      @(posedge clk);
      event_pulse <= 3'(1 << k);
      @(posedge clk);
      event_pulse <= 3'h0;
   endtask
endmodule
`default_nettype wire

// >>> tb/rbt_tuning_regs_tb.sv
// Testbench: register access, averaging, carrier sense and hold timers
// Assumes: rbt_bb_model drives the baseband inputs except CONVERTER_DIV_SEL
`timescale 1ns/1ns
`default_nettype none
module rbt_tuning_regs_tb
   import rbt_pkg::*;
;
   logic        CLK, RESET, cyc, stb, we_r, ack, pair, smp, abv;
   logic        fen, byp, cs, frz, irq, ecs, ocs;
   logic [9:0]  adr;
   logic [3:0]  sel, mant;
   logic [31:0] wdat, rdat, q, rnd, st;
   logic [2:0]  cdiv, evt, c;
   logic [15:0] est, avg;
   logic [1:0]  expo, shf;
   logic [5:0]  ddv;
   int          fail_count, cmp_count, i, s, g, n, ca, cb, sum, e, tol, dv;
   int          tbl[7] = '{16, 20, 24, 28, 32, 40, 48};

   rbt_tuning_regs #(.FW(16)) uut (.CLK(CLK), .RESET(RESET),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we_r), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .CONVERTER_DIV_SEL(cdiv), .FREQ_EST(est), .BIT_PAIR_DONE(pair),
      .CS_SAMPLE(smp), .CS_ABOVE(abv), .FREQ_SWITCH(evt[0]),
      .SYNTH_UNLOCK(evt[1]), .RX_POWER_UP(evt[2]), .AVG_FREQ_OFFSET(avg),
      .FREQ_CORR_EN(fen), .RX_DEVIATION_MANTISSA(mant),
      .RX_DEVIATION_EXPONENT(expo), .FILTER_BYPASS_EN(byp),
      .DECIMATOR_INPUT_SHIFT(shf), .DECIMATION_DIVISOR(ddv),
      .CARRIER_SENSE(cs), .LEVELS_FROZEN(frz), .IRQ(irq));
   rbt_bb_model bb (.clk(CLK), .cs_sample(smp), .cs_above(abv),
      .freq_est(est), .pair_done(pair), .event_pulse(evt));

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] y);
      cmp_count++;
      if (y !== x) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, x, y);
      end
   endtask
   task automatic wb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] m);
      int k;
      k = 0;
      @(posedge CLK);
      {cyc, stb, we_r, adr, wdat, sel} <= {2'b11, w, a, d, m};
      do begin
         @(posedge CLK);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat;
      {cyc, stb} <= 2'b00;
      if (k >= 20) begin
         fail_count++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] x,
                     input string nm);
      wb(1'b0, a, 32'h0, 4'hf);
      chk(nm, x, q);
   endtask
   // Bench carrier model: consecutive hit and miss counts
   task automatic cs_step(input logic lvl, input int set, input int rel);
      bb.sample(lvl);
      ocs = ecs;
      if (lvl) begin
         cb = 0;
         ca++;
         if (ca >= set + 1) ecs = 1'b1;
      end else begin
         ca = 0;
         cb++;
         if (cb >= rel + 1) ecs = 1'b0;
      end
      st = st | {30'h0, ocs & ~ecs, ~ocs & ecs};
      repeat (2) @(posedge CLK);
      chk("carrier", {31'h0, ecs}, {31'h0, cs});
   endtask

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {RESET, cyc, stb, we_r, adr, sel, wdat} = {1'b1, 49'h0};
      {cdiv, rnd, fail_count, cmp_count} = {3'h3, 32'h9a9a96f9, 64'h0};
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      rd(FREQ_CORRECTION_CTRL_ADDR, 32'h9c, "fc_reset");
      rd(CHANNEL_FILTER_CTRL_ADDR, 32'h00, "filt_reset");
      rd(GAIN_HOLD_CARRIER_CTRL_ADDR, 32'h65, "hold_reset");
      rd(10'h3fc, 32'h0, "unmapped");
      for (i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         if (i < 2) rnd[12:8] = {5{i[0]}};
         wr(FREQ_CORRECTION_CTRL_ADDR, {24'h0, rnd[7:0]});
         wr(CHANNEL_FILTER_CTRL_ADDR, {24'h0, rnd[15:8]});
         wb(1'b1, CHANNEL_FILTER_CTRL_ADDR, ~rnd, 4'he);
         wr(10'h3fc, 32'hff);
         rd(FREQ_CORRECTION_CTRL_ADDR, {24'h0, rnd[7:0]}, "fc");
         rd(CHANNEL_FILTER_CTRL_ADDR, {24'h0, rnd[15:8]}, "filt");
         chk("corr_en", {31'h0, rnd[7:6] != 2'h0}, {31'h0, fen});
         chk("dev", {26'h0, rnd[5:0]}, {26'h0, expo, mant});
         chk("filt_out", {23'h0, rnd[15:13], 6'(rnd[12:8]) + 6'h1},
             {23'h0, byp, shf, ddv});
      end
      for (s = 0; s < 4; s++) begin
         wr(FREQ_CORRECTION_CTRL_ADDR, {24'h0, 2'(s), 6'h2c});
         n = (s == 0) ? 1 : 1 << (s - 1);
         sum = 0;
         for (i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            bb.pair({2'b00, rnd[13:2], 2'b00});
            sum += {rnd[13:2], 2'b00};
         end
         repeat (4) @(posedge CLK);
         chk("avg", s == 0 ? 0 : sum / n, {16'h0, avg});
      end
      {ecs, st, ca, cb} = 0;
      wr(IRQ_MASK_ADDR, 32'h7);
      for (s = 0; s < 8; s++) begin
         // Release still follows the previous setting here
         repeat (2) cs_step(1'b0, 3, (s == 0) ? 1 : (s - 1) & 1);
         wr(GAIN_HOLD_CARRIER_CTRL_ADDR, {24'h0, 2'(s >> 1), s[0], 5'h05});
         {ca, cb} = 0;
         for (i = 0; i < 14; i++) begin
            rnd = lfsr(rnd);
            cs_step(rnd[0] | rnd[1], s >> 1, s & 1);
         end
      end
      rd(IRQ_STATUS_ADDR, st, "irq_status");
      rd(BLOCK_STATUS_ADDR, {31'h0, ecs}, "block_status");
      chk("irq_on", {31'h0, st[1:0] != 2'h0}, {31'h0, irq});
      wr(IRQ_MASK_ADDR, 32'h0);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(IRQ_MASK_ADDR, 32'h7);
      rd(IRQ_MASK_ADDR, 32'h7, "irq_mask");
      wr(IRQ_STATUS_ADDR, 32'h3);
      rd(IRQ_STATUS_ADDR, 32'h0, "irq_clear");
      chk("irq_off", 32'h0, {31'h0, irq});
      for (g = 0; g < 8; g++) begin
         rnd = lfsr(rnd);
         dv = (g == 0) ? 1 : 0;
         c = rnd[2:0] | 3'h1;
         cdiv <= c;
         wr(CHANNEL_FILTER_CTRL_ADDR, 32'(dv));
         wr(GAIN_HOLD_CARRIER_CTRL_ADDR, {24'h0, 3'h5, 3'(g), 2'(g % 4)});
         bb.gain_event(g % 3);
         @(posedge CLK);
         chk("frozen", 32'h1, {31'h0, frz});
         rd(BLOCK_STATUS_ADDR, {30'h0, 1'b1, ecs}, "frz_status");
         repeat (500) @(posedge CLK);
         bb.gain_event((g + 1) % 3);
         n = 0;
         while (frz === 1'b1 && n < 12000) begin
            @(posedge CLK);
            n++;
         end
         if (g == 7) begin
            chk("hold_forever", 32'h1, {31'h0, frz});
         end else begin
            e = tbl[g] * FILTER_BASE_CYC * (dv + 1) + (16 << (g % 4)) * (2 * c + 2);
            tol = FILTER_BASE_CYC * (dv + 1) + 2 * c + 6;
            chk("hold_len", 32'h1, {31'h0, n >= e - tol && n <= e + tol});
            rd(IRQ_STATUS_ADDR, 32'h4, "freeze_irq");
            wr(IRQ_STATUS_ADDR, 32'h4);
         end
      end
      end_sim();
   end
endmodule
`default_nettype wire
